// [include/pstwm_pkg.sv]
// package: register map, field positions and timing constants
package pstwm_pkg;
    // ------------------------------------------------------------------
    // register offsets (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [7:0] CTRL_ONE_OFFSET   = 8'h40;
    localparam logic [7:0] TIMER_OFFSET      = 8'h44;
    localparam logic [7:0] STATUS_OFFSET     = 8'h48;
    localparam logic [7:0] MASK_OFFSET       = 8'h4C;
    // ------------------------------------------------------------------
    // fields and reset values
    // ------------------------------------------------------------------
    localparam int         RESERVED_BIT_POS  = 7;
    localparam int         SINGLE_WRITE_POS  = 6;
    localparam logic [7:0] CTRL_ONE_RESET    = 8'h00;
    localparam logic [7:0] CTRL_ONE_WMASK    = 8'h40;
    localparam int         TIMER_EN_POS      = 5;
    localparam logic [5:0] TIMER_RESET       = 6'h00;
    localparam int         ST_ABORT_POS      = 0;
    localparam int         ST_RETRY_POS      = 1;
    localparam int         ST_DISC_POS       = 2;
    localparam int         STATUS_WIDTH      = 3;
    localparam logic [2:0] STATUS_RESET      = 3'h0;
    localparam logic [2:0] MASK_RESET        = 3'h0;
    // ------------------------------------------------------------------
    // timer: five programmed msbs, three implied low bits
    // ------------------------------------------------------------------
    localparam int         TIMER_FIELD_BITS  = 5;
    localparam int         COUNT_BITS        = 8;
    localparam logic [2:0] IMPLIED_LOW_BITS  = 3'h7;
    localparam logic [1:0] RESP_OKAY         = 2'h0;
    localparam logic [1:0] RESP_SLVERR       = 2'h2;
endpackage

// [logic/pstwm_resp_timer.sv]
// response timer: countdown supervising target ready during a master cycle
`timescale 1ns/100ps
module pstwm_resp_timer (
    input  wire logic       clk,        // clock
    input  wire logic       rst,        // synchronous reset, active high
    input  wire logic       enable,     // timer enabled
    input  wire logic [4:0] timer_val,  // programmed five msbs
    input  wire logic       active,     // master cycle in progress
    input  wire logic       data_done,  // valid data phase completed
    output logic            expired     // one-cycle expiry pulse
);
    logic [7:0] count_reg;
    logic [7:0] load_val;
    logic       running_reg;

    assign load_val = {timer_val, pstwm_pkg::IMPLIED_LOW_BITS};

    always_ff @(posedge clk) begin
        if (rst) begin
            count_reg   <= 8'h00;
            running_reg <= 1'b0;
            expired     <= 1'b0;
        end else begin
            expired <= 1'b0;
            if (!active || !enable) begin
                count_reg   <= load_val;
                // armed while idle so the first data phase is supervised
                running_reg <= 1'b1;
            end else if (data_done) begin
                count_reg   <= load_val;
                running_reg <= 1'b1;
            end else if (running_reg) begin
                if (count_reg == 8'h00) begin
                    expired     <= 1'b1;
                    running_reg <= 1'b0;
                end else begin
                    count_reg <= count_reg - 8'h01;
                end
            end
        end
    end

    timer_reload_a: assert property (@(posedge clk) disable iff (rst)
        active && enable && data_done |=> !expired)
        else $error("timer expired right after a data phase");
endmodule

// [logic/pstwm_slave_write.sv]
// slave write phase control: burst or single data phase
`timescale 1ns/100ps
module pstwm_slave_write (
    input  wire logic clk,           // clock
    input  wire logic rst,           // synchronous reset, active high
    input  wire logic single_write,  // single write mode
    input  wire logic frame,         // frame asserted, slave write cycle
    input  wire logic irdy,          // initiator ready
    output logic      trdy,          // target ready
    output logic      stop,          // target stop (disconnect)
    output logic      phase_done     // one data phase completed
);
    logic taken_reg;

    always_ff @(posedge clk) begin
        if (rst) begin
            taken_reg <= 1'b0;
        end else if (!frame) begin
            taken_reg <= 1'b0;
        end else if (phase_done) begin
            taken_reg <= 1'b1;
        end
    end

    // after one phase in single mode the slave refuses further phases
    always_comb begin
        trdy       = frame && !(single_write && taken_reg);
        stop       = frame && single_write && taken_reg;
        phase_done = trdy && irdy;
    end

    single_phase_a: assert property (@(posedge clk) disable iff (rst)
        single_write && frame && phase_done |=>
        (frame -> (!trdy && stop)))
        else $error("second data phase accepted in single write mode");
endmodule

// [logic/pstwm_top.sv]
// top: pci slave response timeout and write mode with axi4-lite registers
// ----------------------------------------------------------------------
// ----------------------------------------------------------------------
//
// The AXI4-Lite interface to the registers was decided locally.
`timescale 1ns/100ps
module pstwm_top (
    input  wire logic        REF_CLK,       // 125 MHz clock
    input  wire logic        RESET,         // synchronous reset, active high
    input  wire logic [7:0]  AWADDR,        // write address
    input  wire logic        AWVALID,       // write address valid
    output logic             AWREADY,       // write address ready
    input  wire logic [31:0] WDATA,         // write data
    input  wire logic [3:0]  WSTRB,         // write strobes
    input  wire logic        WVALID,        // write data valid
    output logic             WREADY,        // write data ready
    output logic [1:0]       BRESP,         // write response
    output logic             BVALID,        // write response valid
    input  wire logic        BREADY,        // write response ready
    input  wire logic [7:0]  ARADDR,        // read address
    input  wire logic        ARVALID,       // read address valid
    output logic             ARREADY,       // read address ready
    output logic [31:0]      RDATA,         // read data
    output logic [1:0]       RRESP,         // read response
    output logic             RVALID,        // read data valid
    input  wire logic        RREADY,        // read data ready
    input  wire logic        MST_ACTIVE,    // own master cycle in progress
    input  wire logic        MST_IRDY,      // own master initiator ready
    input  wire logic        TGT_TRDY,      // target ready sampled
    input  wire logic        TGT_STOP,      // target stop (retry) sampled
    output logic             MASTER_ABORT,  // end cycle with master abort
    output logic             SERR_OUT,      // system error pulse
    input  wire logic        SLV_FRAME,     // slave write cycle frame
    input  wire logic        SLV_IRDY,      // initiator ready toward slave
    output logic             SLV_TRDY,      // slave target ready
    output logic             SLV_STOP,      // slave disconnect
    output logic             IRQ            // level interrupt
);
    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    logic [7:0]  ctrl_one_reg;
    logic [5:0]  timer_reg;
    logic [2:0]  status_reg;
    logic [2:0]  mask_reg;
    logic        aw_hold_reg;
    logic        w_hold_reg;
    logic [7:0]  awaddr_reg;
    logic [31:0] wdata_reg;
    logic [3:0]  wstrb_reg;
    logic        retry_seen_reg;
    logic        expired;
    logic        slv_trdy;
    logic        slv_stop;
    logic        slv_done;
    logic        do_write;
    logic [2:0]  w1c_mask;
    logic [2:0]  events;
    logic [31:0] rd_word;

    // ------------------------------------------------------------------
    // sub-blocks
    // ------------------------------------------------------------------
    pstwm_resp_timer u_timer (
        .clk       (REF_CLK),
        .rst       (RESET),
        .enable    (timer_reg[pstwm_pkg::TIMER_EN_POS]),
        .timer_val (timer_reg[4:0]),
        .active    (MST_ACTIVE && !MASTER_ABORT),
        .data_done (MST_IRDY && TGT_TRDY),
        .expired   (expired)
    );

    pstwm_slave_write u_swr (
        .clk          (REF_CLK),
        .rst          (RESET),
        .single_write (ctrl_one_reg[pstwm_pkg::SINGLE_WRITE_POS]),
        .frame        (SLV_FRAME),
        .irdy         (SLV_IRDY),
        .trdy         (slv_trdy),
        .stop         (slv_stop),
        .phase_done   (slv_done)
    );

    // ------------------------------------------------------------------
    // axi4-lite write channel
    // ------------------------------------------------------------------
    assign do_write = aw_hold_reg && w_hold_reg && !BVALID;

    always_ff @(posedge REF_CLK) begin
        if (RESET) begin
            AWREADY     <= 1'b0;
            WREADY      <= 1'b0;
            aw_hold_reg <= 1'b0;
            w_hold_reg  <= 1'b0;
            awaddr_reg  <= 8'h00;
            wdata_reg   <= 32'h0000_0000;
            wstrb_reg   <= 4'h0;
            BVALID      <= 1'b0;
            BRESP       <= pstwm_pkg::RESP_OKAY;
        end else begin
            AWREADY <= !aw_hold_reg && !AWREADY && !AWVALID ? 1'b0 :
                       !aw_hold_reg && !AWREADY;
            WREADY  <= !w_hold_reg && !WREADY && WVALID;
            if (AWVALID && AWREADY) begin
                aw_hold_reg <= 1'b1;
                awaddr_reg  <= AWADDR;
            end
            if (WVALID && WREADY) begin
                w_hold_reg <= 1'b1;
                wdata_reg  <= WDATA;
                wstrb_reg  <= WSTRB;
            end
            if (do_write) begin
                aw_hold_reg <= 1'b0;
                w_hold_reg  <= 1'b0;
                BVALID      <= 1'b1;
                case (awaddr_reg)
                    pstwm_pkg::CTRL_ONE_OFFSET,
                    pstwm_pkg::TIMER_OFFSET,
                    pstwm_pkg::STATUS_OFFSET,
                    pstwm_pkg::MASK_OFFSET: BRESP <= pstwm_pkg::RESP_OKAY;
                    default:                BRESP <= pstwm_pkg::RESP_SLVERR;
                endcase
            end else if (BVALID && BREADY) begin
                BVALID <= 1'b0;
            end
        end
    end

    // reserved msb is not stored, reads zero
    always_ff @(posedge REF_CLK) begin
        if (RESET) begin
            ctrl_one_reg <= pstwm_pkg::CTRL_ONE_RESET;
            timer_reg    <= pstwm_pkg::TIMER_RESET;
            mask_reg     <= pstwm_pkg::MASK_RESET;
        end else if (do_write && wstrb_reg[0]) begin
            if (awaddr_reg == pstwm_pkg::CTRL_ONE_OFFSET) begin
                // reserved msb is dropped whatever software writes
                ctrl_one_reg <= wdata_reg[7:0] &
                                pstwm_pkg::CTRL_ONE_WMASK;
            end
            if (awaddr_reg == pstwm_pkg::TIMER_OFFSET) begin
                timer_reg <= wdata_reg[5:0];
            end
            if (awaddr_reg == pstwm_pkg::MASK_OFFSET) begin
                mask_reg <= wdata_reg[2:0];
            end
        end
    end

    // ------------------------------------------------------------------
    // master abort, system error, slave pins
    // ------------------------------------------------------------------
    always_ff @(posedge REF_CLK) begin
        if (RESET) begin
            MASTER_ABORT   <= 1'b0;
            SERR_OUT       <= 1'b0;
            retry_seen_reg <= 1'b0;
            SLV_TRDY       <= 1'b0;
            SLV_STOP       <= 1'b0;
        end else begin
            SLV_TRDY <= slv_trdy;
            SLV_STOP <= slv_stop;
            SERR_OUT <= expired;
            if (!MST_ACTIVE) begin
                MASTER_ABORT   <= 1'b0;
                retry_seen_reg <= 1'b0;
            end else begin
                if (TGT_STOP) begin
                    retry_seen_reg <= 1'b1;
                end
                if (expired) begin
                    MASTER_ABORT <= 1'b1;
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // interrupt status, write one to clear, set wins
    // ------------------------------------------------------------------
    always_comb begin
        events = 3'h0;
        events[pstwm_pkg::ST_ABORT_POS] = expired && !retry_seen_reg;
        events[pstwm_pkg::ST_RETRY_POS] = expired && retry_seen_reg;
        events[pstwm_pkg::ST_DISC_POS]  = slv_stop && !SLV_STOP;
        w1c_mask = 3'h0;
        if (do_write && wstrb_reg[0] &&
            awaddr_reg == pstwm_pkg::STATUS_OFFSET) begin
            w1c_mask = wdata_reg[2:0];
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (RESET) begin
            status_reg <= pstwm_pkg::STATUS_RESET;
            IRQ        <= 1'b0;
        end else begin
            status_reg <= (status_reg & ~w1c_mask) | events;
            IRQ        <= |(((status_reg & ~w1c_mask) | events) & mask_reg);
        end
    end

    // ------------------------------------------------------------------
    // axi4-lite read channel
    // ------------------------------------------------------------------
    always_comb begin
        rd_word = 32'h0000_0000;
        case (ARADDR)
            pstwm_pkg::CTRL_ONE_OFFSET: rd_word[7:0] = ctrl_one_reg;
            pstwm_pkg::TIMER_OFFSET:    rd_word[5:0] = timer_reg;
            pstwm_pkg::STATUS_OFFSET:   rd_word[2:0] = status_reg;
            pstwm_pkg::MASK_OFFSET:     rd_word[2:0] = mask_reg;
            default:                    rd_word = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge REF_CLK) begin
        if (RESET) begin
            ARREADY <= 1'b0;
            RVALID  <= 1'b0;
            RDATA   <= 32'h0000_0000;
            RRESP   <= pstwm_pkg::RESP_OKAY;
        end else begin
            ARREADY <= 1'b0;
            if (ARVALID && !ARREADY && !RVALID) begin
                ARREADY <= 1'b1;
                RVALID  <= 1'b1;
                RDATA   <= rd_word;
                case (ARADDR)
                    pstwm_pkg::CTRL_ONE_OFFSET,
                    pstwm_pkg::TIMER_OFFSET,
                    pstwm_pkg::STATUS_OFFSET,
                    pstwm_pkg::MASK_OFFSET: RRESP <= pstwm_pkg::RESP_OKAY;
                    default:                RRESP <= pstwm_pkg::RESP_SLVERR;
                endcase
            end else if (RVALID && RREADY) begin
                RVALID <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    abort_on_expiry_a: assert property (@(posedge REF_CLK) disable iff (RESET)
        expired && MST_ACTIVE |=> MASTER_ABORT && SERR_OUT)
        else $error("expiry did not abort the cycle");
    retry_abort_a: assert property (@(posedge REF_CLK) disable iff (RESET)
        expired && retry_seen_reg && MST_ACTIVE |=> MASTER_ABORT)
        else $error("retried cycle not aborted on expiry");
    serr_cause_a: assert property (@(posedge REF_CLK) disable iff (RESET)
        SERR_OUT |-> $past(expired))
        else $error("system error without expiry");
    burst_write_a: assert property (@(posedge REF_CLK) disable iff (RESET)
        !ctrl_one_reg[pstwm_pkg::SINGLE_WRITE_POS] |-> !slv_stop)
        else $error("disconnect in burst write mode");
    reserved_zero_a: assert property (@(posedge REF_CLK) disable iff (RESET)
        !ctrl_one_reg[pstwm_pkg::RESERVED_BIT_POS])
        else $error("reserved bit stored");
    irq_level_a: assert property (@(posedge REF_CLK) disable iff (RESET)
        IRQ |-> $past(|((status_reg & ~w1c_mask | events) & mask_reg)))
        else $error("interrupt without unmasked status");
    abort_hold_a: assert property (@(posedge REF_CLK) disable iff (RESET)
        MASTER_ABORT && MST_ACTIVE |=> MASTER_ABORT)
        else $error("master abort dropped inside the cycle");
    abort_release_a: assert property (@(posedge REF_CLK) disable iff (RESET)
        !MST_ACTIVE |=> !MASTER_ABORT)
        else $error("master abort held after the cycle");
    status_set_a: assert property (@(posedge REF_CLK) disable iff (RESET)
        |events |=> |status_reg)
        else $error("event did not set a status bit");
    rvalid_hold_a: assert property (@(posedge REF_CLK) disable iff (RESET)
        RVALID && !RREADY |=> RVALID && $stable(RDATA))
        else $error("read data withdrawn before handshake");
    bvalid_hold_a: assert property (@(posedge REF_CLK) disable iff (RESET)
        BVALID && !BREADY |=> BVALID && $stable(BRESP))
        else $error("write response withdrawn before handshake");
    aw_pending_a: assert property (@(posedge REF_CLK) disable iff (RESET)
        aw_hold_reg |-> !AWREADY)
        else $error("address accepted while a write is pending");
    w_pending_a: assert property (@(posedge REF_CLK) disable iff (RESET)
        w_hold_reg |-> !WREADY)
        else $error("data accepted while a write is pending");
    // ------------------------------------------------------------------
    // main scenarios reached
    // ------------------------------------------------------------------
    timer_abort_c: cover property (@(posedge REF_CLK) disable iff (RESET)
        MST_ACTIVE ##1 MASTER_ABORT);
    single_disc_c: cover property (@(posedge REF_CLK) disable iff (RESET)
        SLV_FRAME && SLV_STOP);
    irq_c: cover property (@(posedge REF_CLK) disable iff (RESET) IRQ);
    retry_abort_c: cover property (@(posedge REF_CLK) disable iff (RESET)
        retry_seen_reg && expired);
    burst_write_c: cover property (@(posedge REF_CLK) disable iff (RESET)
        slv_done ##1 slv_done);
endmodule

// [sim/pstwm_target_model.sv]
// target agent model answering the block's own master cycles
`timescale 1ns/100ps
module pstwm_target_model (
    input  wire logic       clk,    // clock
    input  wire logic       rst,    // synchronous reset, active high
    input  wire logic       active, // master cycle in progress
    input  wire logic       irdy,   // initiator ready
    input  wire logic [7:0] delay,  // wait states before target ready
    input  wire logic       retry,  // keep signalling retry
    output logic            trdy,   // target ready pulse
    output logic            stop    // retry level
);
    logic [7:0] wait_reg;
    // ------------------------------------------------------------------
    // wait-state counter, ready pulse after delay cycles
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst || !active || retry) begin
            wait_reg <= 8'h00;
            trdy     <= 1'b0;
        end else if (irdy && wait_reg >= delay) begin
            wait_reg <= 8'h00;
            trdy     <= 1'b1;
        end else begin
            wait_reg <= wait_reg + 8'h01;
            trdy     <= 1'b0;
        end
    end
    always_ff @(posedge clk) begin
        stop <= !rst && active && retry;
    end
endmodule

// [sim/pci_slave_timeout_and_write_mode_test.sv]
// testbench: registers, response timer, slave write modes, interrupt
`timescale 1ns/100ps
module pci_slave_timeout_and_write_mode_test;
    logic REF_CLK = 1'b0, RESET = 1'b1;
    logic [7:0] AWADDR = 8'h00, ARADDR = 8'h00, delay = 8'h00;
    logic [31:0] WDATA = 32'h0, RDATA, rd;
    logic [3:0] WSTRB = 4'hF;
    logic AWVALID = 0, WVALID = 0, BREADY = 0, ARVALID = 0, RREADY = 0;
    logic AWREADY, WREADY, BVALID, ARREADY, RVALID, IRQ, retry = 0;
    logic [1:0] BRESP, RRESP, rsp;
    logic MST_ACTIVE = 0, MST_IRDY = 0, SLV_FRAME = 0, SLV_IRDY = 0;
    logic TGT_TRDY, TGT_STOP, MASTER_ABORT, SERR_OUT, SLV_TRDY, SLV_STOP;
    int err_total = 0, tests_run = 0, seed = 78, serrs, ph, st, v;
    pstwm_top dut (.REF_CLK(REF_CLK), .RESET(RESET), .AWADDR(AWADDR),
        .AWVALID(AWVALID), .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(WSTRB),
        .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID),
        .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID),
        .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID),
        .RREADY(RREADY), .MST_ACTIVE(MST_ACTIVE), .MST_IRDY(MST_IRDY),
        .TGT_TRDY(TGT_TRDY), .TGT_STOP(TGT_STOP),
        .MASTER_ABORT(MASTER_ABORT), .SERR_OUT(SERR_OUT),
        .SLV_FRAME(SLV_FRAME), .SLV_IRDY(SLV_IRDY), .SLV_TRDY(SLV_TRDY),
        .SLV_STOP(SLV_STOP), .IRQ(IRQ));
    pstwm_target_model tgt (.clk(REF_CLK), .rst(RESET), .active(MST_ACTIVE),
        .irdy(MST_IRDY), .delay(delay), .retry(retry), .trdy(TGT_TRDY),
        .stop(TGT_STOP));
    initial begin
        forever #4 REF_CLK = ~REF_CLK;
    end
    // ------------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value at %0t: seen %h expected %h", $time,
                     seen, exp);
        end
    endtask
    task automatic report_and_stop();
        $display("errors %0d, comparisons %0d", err_total, tests_run);
        if (err_total == 0 && tests_run > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        AWADDR <= a; WDATA <= d; AWVALID <= 1'b1; WVALID <= 1'b1;
        BREADY <= 1'b1;
        do begin
            @(posedge REF_CLK);
            if (AWREADY) AWVALID <= 1'b0;
            if (WREADY) WVALID <= 1'b0;
        end while (!BVALID);
        rsp = BRESP;
        BREADY <= 1'b0;
        @(posedge REF_CLK);
    endtask
    task automatic rdr(input logic [7:0] a);
        ARADDR <= a; ARVALID <= 1'b1; RREADY <= 1'b1;
        do begin
            @(posedge REF_CLK);
            if (ARREADY) ARVALID <= 1'b0;
        end while (!RVALID);
        rd = RDATA; rsp = RRESP;
        RREADY <= 1'b0;
        @(posedge REF_CLK);
    endtask
    // run a master cycle for n cycles and count error pulses, leaving it active for end_cycle
    task automatic master_cycle(input int n);
        serrs = 0;
        MST_ACTIVE <= 1'b1; MST_IRDY <= 1'b1;
        repeat (n) begin
            @(posedge REF_CLK);
            if (SERR_OUT === 1'b1) serrs++;
        end
    endtask
    task automatic end_cycle();
        MST_ACTIVE <= 1'b0; MST_IRDY <= 1'b0; retry <= 1'b0;
        repeat (3) @(posedge REF_CLK);
    endtask
    task automatic slave_frame();
        ph = 0; st = 0;
        SLV_FRAME <= 1'b1; SLV_IRDY <= 1'b1;
        repeat (8) begin
            @(posedge REF_CLK);
            if (SLV_TRDY === 1'b1) ph++;
            if (SLV_STOP === 1'b1) st = 1;
        end
        SLV_FRAME <= 1'b0; SLV_IRDY <= 1'b0;
        repeat (3) @(posedge REF_CLK);
    endtask
    initial begin
        #(8 * 30000);
        err_total++;
        report_and_stop();
    end
    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        repeat (10) @(posedge REF_CLK);
        RESET <= 1'b0;
        @(posedge REF_CLK);
        rdr(pstwm_pkg::CTRL_ONE_OFFSET); chk(rd, 32'h0);
        rdr(pstwm_pkg::TIMER_OFFSET); chk(rd, 32'h0);
        rdr(8'h50); chk({30'h0, rsp}, {30'h0, pstwm_pkg::RESP_SLVERR});
        wr(8'h50, 32'h7); chk({30'h0, rsp}, {30'h0, pstwm_pkg::RESP_SLVERR});
        wr(pstwm_pkg::MASK_OFFSET, 32'h7);
        chk({30'h0, rsp}, {30'h0, pstwm_pkg::RESP_OKAY});
        rdr(pstwm_pkg::MASK_OFFSET); chk(rd, 32'h7);
        chk({30'h0, rsp}, {30'h0, pstwm_pkg::RESP_OKAY});
        wr(pstwm_pkg::CTRL_ONE_OFFSET, 32'h40);
        rdr(pstwm_pkg::CTRL_ONE_OFFSET); chk(rd, 32'h40);
        slave_frame(); chk(ph, 32'd1);
        chk(st, 32'd1);
        chk(IRQ, 1'b1);
        rdr(pstwm_pkg::STATUS_OFFSET); chk(rd[2], 1'b1);
        wr(pstwm_pkg::CTRL_ONE_OFFSET, 32'h00);
        slave_frame(); chk(ph > 1, 32'd1);
        chk(st, 32'd0);
        wr(pstwm_pkg::STATUS_OFFSET, 32'h7);
        chk(IRQ, 1'b0);
        for (int i = 0; i < 6; i++) begin
            v = 1 + ($unsigned($random(seed)) % 31);
            delay <= 8'($unsigned($random(seed)) % (8 * v - 2));
            wr(pstwm_pkg::TIMER_OFFSET, 32'h20 | v);
            master_cycle(300); chk(MASTER_ABORT, 1'b0);
            chk(serrs, 0);
            end_cycle();
        end
        wr(pstwm_pkg::TIMER_OFFSET, 32'h21);
        delay <= 8'd40;
        master_cycle(60); chk(serrs, 1);
        chk(MASTER_ABORT, 1'b1);
        chk(IRQ, 1'b1);
        end_cycle(); chk(MASTER_ABORT, 1'b0);
        rdr(pstwm_pkg::STATUS_OFFSET); chk(rd[0], 1'b1);
        wr(pstwm_pkg::MASK_OFFSET, 32'h0);
        chk(IRQ, 1'b0);
        wr(pstwm_pkg::MASK_OFFSET, 32'h7);
        wr(pstwm_pkg::STATUS_OFFSET, 32'h1);
        chk(IRQ, 1'b0);
        retry <= 1'b1;
        master_cycle(60); chk(serrs, 1);
        chk(MASTER_ABORT, 1'b1);
        end_cycle();
        rdr(pstwm_pkg::STATUS_OFFSET); chk(rd[1], 1'b1);
        wr(pstwm_pkg::TIMER_OFFSET, 32'h01);
        delay <= 8'd40;
        master_cycle(80); chk(serrs, 0);
        end_cycle();
        report_and_stop();
    end
endmodule
